// ===== hw/pfs_consts.svh
// Constants for the pin function select and reset pin block
`ifndef PFS_CONSTS_SVH
`define PFS_CONSTS_SVH

// Register bus geometry
`define PFS_ADDR_W       4
`define PFS_DATA_W       8

// Register offsets
`define PFS_OFS_PER      4'h0
`define PFS_OFS_GPS      4'h1
`define PFS_OFS_DDR      4'h2
`define PFS_OFS_DOUT     4'h3
`define PFS_OFS_DIN      4'h4
`define PFS_OFS_PUE      4'h5
`define PFS_OFS_OSC      4'h6
`define PFS_OFS_RSTCTL   4'h7

// Field positions
`define PFS_OSC_MODE_BIT 0
`define PFS_OSC_SEL_BIT  1
`define PFS_RST_SW_BIT   0
`define PFS_RST_GPIO_BIT 1
`define PFS_RST_BUSY_BIT 2
`define PFS_PIN_RST      3

// Reset values
`define PFS_PER_RST      4'h0
`define PFS_GPS_RST      4'h0
`define PFS_DDR_RST      4'h0
`define PFS_DOUT_RST     4'h0
`define PFS_PUE_RST      4'hf

// Internal reset stretch after the last reset source drops
`define PFS_RST_HOLD     6'h20

`endif

// ===== hw/pfs_pkg.sv
// Types for the pin function select and reset pin block
package pfs_pkg;

  // Source feeding the device clock
  typedef enum logic [1:0] {
    PFS_CLK_INT,
    PFS_CLK_PIN,
    PFS_CLK_CRYSTAL_PIN
  } pfs_clk_src_type;

  // Whole state of the block
  typedef struct packed {
    logic [3:0]      per;
    logic [3:0]      gps;
    logic [3:0]      ddr;
    logic [3:0]      dout;
    logic [3:0]      pue;
    logic            ext_mode;
    logic            external_source_select_bit;
    logic            sw_req;
    logic [5:0]      cnt;
    logic [3:0]      pin_o;
    logic [3:0]      pin_oe;
    logic [3:0]      pin_pu;
    logic [7:0]      rdata;
    logic            chip_rst_b;
    pfs_clk_src_type clk_src;
  } pfs_state_type;

endpackage

// ===== hw/pfs_pin_mux.sv
// Pin function select, clock source select and reset pin logic
//
// Overview of operation
// - After any reset each pin keeps its primary function until reprogrammed.
// - Alternate function needs peripheral enable and system select both set.
// - External clock source needs the external clock mode bit set.
// - External source select bit picks clock input pin or crystal pin.
// - Reset pin low in reset function resets and holds the whole device.
// - Internal reset ends synchronously, fixed cycle count after pin release.
// - Reset pin reprogrammed as port A bit 7 GPIO is ignored as reset.
// - In GPIO mode only power-on, watchdog or software reset resets device.
// - Port A bit 7 defaults to reset function; bits 0 to 2 to GPIO.
// - As GPIO each port pin direction is set independently as input or output.
// - Alternate function of port A bits 0, 1, 2 is PWM channels 0, 1, 2.
//
// Pin index 0..2 is port A bit 0..2, pin index 3 is port A bit 7.
`include "pfs_consts.svh"

module pfs_pin_mux (
  input  wire logic                     CLK_SYS_I,
  input  wire logic                     RST_B_I,
  input  wire logic [`PFS_ADDR_W-1:0]   ADDR_I,
  input  wire logic [`PFS_DATA_W-1:0]   WDATA_I,
  input  wire logic                     WR_I,
  input  wire logic                     RD_I,
  output logic      [`PFS_DATA_W-1:0]   RDATA_O,
  input  wire logic [3:0]               PA_I,
  output logic      [3:0]               PA_O,
  output logic      [3:0]               PA_OE_O,
  output logic      [3:0]               PA_PU_O,
  input  wire logic [2:0]               PWM_CH_I,
  input  wire logic                     WDOG_RST_I,
  output pfs_pkg::pfs_clk_src_type      CLK_SRC_O,
  output logic                          CHIP_RST_B_O
);
  import pfs_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Declarations

  localparam pfs_state_type RST_STATE = '{
    per:     `PFS_PER_RST,
    gps:     `PFS_GPS_RST,
    ddr:     `PFS_DDR_RST,
    dout:    `PFS_DOUT_RST,
    pue:     `PFS_PUE_RST,
    cnt:     `PFS_RST_HOLD,
    pin_pu:  `PFS_PUE_RST,
    clk_src: PFS_CLK_INT,
    default: '0
  };

  pfs_state_type s;
  pfs_state_type next_s;
  logic [3:0]    alt;
  logic [3:0]    gpio_o;
  logic [3:0]    gpio_oe;
  logic [2:0]    periph;
  logic          rst_pin_mode;
  logic          rst_src;
  logic          in_rst;

  //////////////////////////////////////////////////////////////////////////
  // Per-pin function select

  // Peripheral driving pins 0 to 2; bit 7 has no output peripheral
  assign periph = PWM_CH_I;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      // Alternate only with both enables set
      assign alt[gi] = s.per[gi] & s.gps[gi];
      if (gi == `PFS_PIN_RST) begin : g_rst_pin
        // Bit 7 drives only as GPIO, never in reset function
        assign gpio_o[gi]  = s.dout[gi];
        assign gpio_oe[gi] = alt[gi] & s.ddr[gi];
      end else begin : g_pwm_pin
        // Data and direction of the selected function
        assign gpio_o[gi]  = alt[gi] ? periph[gi] : s.dout[gi];
        assign gpio_oe[gi] = alt[gi] | s.ddr[gi];
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Reset sources

  // Reset pin acts as reset unless switched to GPIO
  assign rst_pin_mode = ~alt[`PFS_PIN_RST];
  // Watchdog, software and pin sources
  assign rst_src = WDOG_RST_I | s.sw_req
                 | (rst_pin_mode & ~PA_I[`PFS_PIN_RST]);
  // Held in reset while a source stands or the stretch runs
  assign in_rst  = rst_src | (s.cnt != 6'h00);

  //////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_s = s;
    next_s.sw_req = 1'b0;
    next_s.rdata  = 8'h00;
    // Stretch counter reloads while any source stands
    if (rst_src) begin
      next_s.cnt = `PFS_RST_HOLD;
    end else if (s.cnt != 6'h00) begin
      next_s.cnt = s.cnt - 6'h01;
    end
    next_s.chip_rst_b = ~in_rst;
    if (in_rst) begin
      // Configuration back to primary functions
      next_s.per      = `PFS_PER_RST;
      next_s.gps      = `PFS_GPS_RST;
      next_s.ddr      = `PFS_DDR_RST;
      next_s.dout     = `PFS_DOUT_RST;
      next_s.pue      = `PFS_PUE_RST;
      next_s.ext_mode = 1'b0;
      next_s.external_source_select_bit  = 1'b0;
      next_s.clk_src  = PFS_CLK_INT;
      // Pins are pulled-up inputs
      next_s.pin_o    = 4'h0;
      next_s.pin_oe   = 4'h0;
      next_s.pin_pu   = 4'hf;
    end else begin
      // Register writes
      if (WR_I) begin
        case (ADDR_I)
          `PFS_OFS_PER:  next_s.per  = {WDATA_I[7], WDATA_I[2:0]};
          `PFS_OFS_GPS:  next_s.gps  = {WDATA_I[7], WDATA_I[2:0]};
          `PFS_OFS_DDR:  next_s.ddr  = {WDATA_I[7], WDATA_I[2:0]};
          `PFS_OFS_DOUT: next_s.dout = {WDATA_I[7], WDATA_I[2:0]};
          `PFS_OFS_PUE:  next_s.pue  = {WDATA_I[7], WDATA_I[2:0]};
          `PFS_OFS_OSC: begin
            next_s.ext_mode = WDATA_I[`PFS_OSC_MODE_BIT];
            next_s.external_source_select_bit  = WDATA_I[`PFS_OSC_SEL_BIT];
          end
          `PFS_OFS_RSTCTL: next_s.sw_req = WDATA_I[`PFS_RST_SW_BIT];
          default: ;
        endcase
      end
      // Register reads, data in the following cycle
      if (RD_I) begin
        case (ADDR_I)
          `PFS_OFS_PER:  next_s.rdata = {s.per[3], 4'h0, s.per[2:0]};
          `PFS_OFS_GPS:  next_s.rdata = {s.gps[3], 4'h0, s.gps[2:0]};
          `PFS_OFS_DDR:  next_s.rdata = {s.ddr[3], 4'h0, s.ddr[2:0]};
          `PFS_OFS_DOUT: next_s.rdata = {s.dout[3], 4'h0, s.dout[2:0]};
          `PFS_OFS_DIN:  next_s.rdata = {PA_I[3], 4'h0, PA_I[2:0]};
          `PFS_OFS_PUE:  next_s.rdata = {s.pue[3], 4'h0, s.pue[2:0]};
          `PFS_OFS_OSC:  next_s.rdata = {6'h00, s.external_source_select_bit, s.ext_mode};
          `PFS_OFS_RSTCTL: begin
            next_s.rdata[`PFS_RST_GPIO_BIT] = ~rst_pin_mode;
            next_s.rdata[`PFS_RST_BUSY_BIT] = s.sw_req;
          end
          default: next_s.rdata = 8'h00;
        endcase
      end
      // Clock source needs the mode bit, then the select bit
      if (!s.ext_mode) begin
        next_s.clk_src = PFS_CLK_INT;
      end else if (s.external_source_select_bit) begin
        next_s.clk_src = PFS_CLK_CRYSTAL_PIN;
      end else begin
        next_s.clk_src = PFS_CLK_PIN;
      end
      // Pin drive; reset pin never drives in reset function
      next_s.pin_o  = gpio_o;
      next_s.pin_oe = gpio_oe;
      next_s.pin_pu = s.pue & ~gpio_oe;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      s <= RST_STATE;
    end else begin
      s <= next_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  assign RDATA_O      = s.rdata;
  assign PA_O         = s.pin_o;
  assign PA_OE_O      = s.pin_oe;
  assign PA_PU_O      = s.pin_pu;
  assign CLK_SRC_O    = s.clk_src;
  assign CHIP_RST_B_O = s.chip_rst_b;

  //////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb_sys @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RST_B_I);

  // Release of internal reset finds primary functions
  AST_PRIMARY_AFTER_RST: assert property (
    $rose(CHIP_RST_B_O) |-> (s.per == 4'h0 && s.gps == 4'h0))
    else $error("pin not in primary function after reset");

  // Alternate drives the PWM channel
  AST_ALT_PWM: assert property (
    (!in_rst && alt[0]) |=> (PA_O[0] == $past(PWM_CH_I[0]) && PA_OE_O[0]))
    else $error("alternate function not routed to pin");

  // Without both enables the GPIO data drives the pin
  AST_NO_ALT: assert property (
    (!in_rst && !alt[1]) |=> (PA_O[1] == $past(s.dout[1])))
    else $error("alternate function routed without both enables");

  // External clock needs the mode bit
  AST_CLK_MODE: assert property (
    (!in_rst && !s.ext_mode) |=> (CLK_SRC_O == PFS_CLK_INT))
    else $error("external clock used without mode bit");

  // Source select picks pin or crystal
  AST_CLK_SEL: assert property (
    (!in_rst && s.ext_mode) |=>
      (CLK_SRC_O == ($past(s.external_source_select_bit) ? PFS_CLK_CRYSTAL_PIN : PFS_CLK_PIN)))
    else $error("wrong external clock source");

  // Reset pin low holds the device in reset
  AST_PIN_RESET: assert property (
    (rst_pin_mode && !PA_I[`PFS_PIN_RST]) |=>
      (!CHIP_RST_B_O && s.cnt == `PFS_RST_HOLD))
    else $error("reset pin did not reset the device");

  // Reset released exactly at end of stretch
  AST_RST_STRETCH: assert property (
    (!rst_src && s.cnt == 6'h01) ##1 !rst_src |=> CHIP_RST_B_O)
    else $error("internal reset not released after stretch");

  // Stretch counting holds reset
  AST_RST_HELD: assert property (
    (s.cnt != 6'h00) |=> !CHIP_RST_B_O)
    else $error("internal reset dropped during stretch");

  // Reset pin in GPIO mode is ignored
  AST_PIN_IGNORED: assert property (
    (!rst_pin_mode && !WDOG_RST_I && !s.sw_req && s.cnt == 6'h00)
      |=> CHIP_RST_B_O)
    else $error("reset pin acted while in GPIO mode");

  // Watchdog resets in every mode
  AST_WDOG_RESET: assert property (
    WDOG_RST_I |=> (!CHIP_RST_B_O ##1 !CHIP_RST_B_O))
    else $error("watchdog did not reset the device");

  // Direction follows the direction register
  AST_DIRECTION: assert property (
    (!in_rst && !alt[2]) |=> (PA_OE_O[2] == $past(s.ddr[2])))
    else $error("pin direction not from direction register");

  // During reset pins are pulled-up inputs
  AST_RST_PINS: assert property (
    in_rst |=> (PA_OE_O == 4'h0 && PA_PU_O == 4'hf))
    else $error("pins not pulled-up inputs during reset");

  // Reset function is the default of bit 7
  AST_BIT7_DEFAULT: assert property (
    $rose(CHIP_RST_B_O) |-> rst_pin_mode)
    else $error("bit 7 not in reset function after reset");

  // Channel 1 carries its PWM output
  AST_ALT_CH1: assert property (
    (!in_rst && alt[1]) |=> (PA_O[1] == $past(PWM_CH_I[1]) && PA_OE_O[1]))
    else $error("channel 1 not routed to pin 1");

  // Channel 2 carries its PWM output
  AST_ALT_CH2: assert property (
    (!in_rst && alt[2]) |=> (PA_O[2] == $past(PWM_CH_I[2]) && PA_OE_O[2]))
    else $error("channel 2 not routed to pin 2");

  // Peripheral enable alone keeps the GPIO data
  AST_PER_ONLY: assert property (
    (!in_rst && s.per[0] && !s.gps[0]) |=> (PA_O[0] == $past(s.dout[0])))
    else $error("alternate routed with peripheral enable only");

  // System select alone keeps the GPIO data
  AST_GPS_ONLY: assert property (
    (!in_rst && !s.per[0] && s.gps[0]) |=> (PA_O[0] == $past(s.dout[0])))
    else $error("alternate routed with system select only");

  // Bit 7 as GPIO follows direction and data registers
  AST_BIT7_GPIO: assert property (
    (!in_rst && alt[3]) |=>
      (PA_OE_O[3] == $past(s.ddr[3]) && PA_O[3] == $past(s.dout[3])))
    else $error("bit 7 GPIO drive wrong");

  // Bit 7 in reset function is an input only
  AST_BIT7_INPUT: assert property (
    (!in_rst && !alt[3]) |=> !PA_OE_O[3])
    else $error("reset pin driven in reset function");

  // Pin 0 direction from the direction register
  AST_DIR_CH0: assert property (
    (!in_rst && !alt[0]) |=> (PA_OE_O[0] == $past(s.ddr[0])))
    else $error("pin 0 direction not from direction register");

  // Software request resets the device
  AST_SW_RESET: assert property (
    s.sw_req |=> (!CHIP_RST_B_O && s.cnt == `PFS_RST_HOLD))
    else $error("software reset not applied");

  // Watchdog resets while the reset pin is GPIO
  AST_WDOG_GPIO: assert property (
    (WDOG_RST_I && !rst_pin_mode) |=> !CHIP_RST_B_O)
    else $error("watchdog ignored in GPIO mode");

  // Any reset source reloads the stretch
  AST_RST_RELOAD: assert property (
    rst_src |=> (s.cnt == `PFS_RST_HOLD))
    else $error("stretch not reloaded by reset source");

  // Stretch counts down one per cycle
  AST_COUNT_DOWN: assert property (
    (!rst_src && s.cnt != 6'h00) |=> (s.cnt == $past(s.cnt) - 6'h01))
    else $error("stretch counter not counting down");

  // Reset puts every pin back to primary function
  AST_CFG_CLEARED: assert property (
    in_rst |=> (s.per == `PFS_PER_RST && s.gps == `PFS_GPS_RST))
    else $error("function select not cleared by reset");

  // Reset falls back to the internal clock
  AST_CLK_IN_RST: assert property (
    in_rst |=> (CLK_SRC_O == PFS_CLK_INT))
    else $error("external clock kept during reset");

  // Reset clears the oscillator bits
  AST_OSC_CLEARED: assert property (
    in_rst |=> (!s.ext_mode && !s.external_source_select_bit))
    else $error("oscillator bits kept through reset");

  // Pins 0 to 2 come back as GPIO after reset
  AST_GPIO_DEFAULT: assert property (
    $rose(CHIP_RST_B_O) |-> (alt[2:0] == 3'h0))
    else $error("pins 0 to 2 not GPIO after reset");

  // Main scenarios
  COV_ALT_PWM:   cover property (!in_rst && alt[0] && PWM_CH_I[0]);
  COV_PIN_RESET: cover property (rst_pin_mode && !PA_I[`PFS_PIN_RST]);
  COV_GPIO_MODE: cover property (!rst_pin_mode && !PA_I[`PFS_PIN_RST]);
  COV_SW_RESET:  cover property (s.sw_req ##1 !CHIP_RST_B_O);
  COV_CRYSTAL_PIN:      cover property (CLK_SRC_O == PFS_CLK_CRYSTAL_PIN);

endmodule // pfs_pin_mux

// ===== testbench/pfs_board.sv
// Board circuitry and PWM source facing the pin mux
module pfs_board (
  input  wire logic       clk_i,
  input  wire logic [3:0] pa_o_i,
  input  wire logic [3:0] pa_oe_i,
  input  wire logic [3:0] pa_pu_i,
  input  wire logic [3:0] drv_i,
  input  wire logic [3:0] lvl_i,
  output logic      [3:0] pa_lvl_o,
  output logic      [2:0] pwm_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] cnt = 3'h0;
  // PWM channel 0 toggles every cycle, channels 1 and 2 every 2 and 4 cycles
  always @(posedge clk_i) cnt <= cnt + 3'h1;
  assign pwm_o = cnt ^ 3'h5;
  // Wire level: device, board, pull-up, else a moving float
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (pa_oe_i[i]) pa_lvl_o[i] = pa_o_i[i];
      else if (drv_i[i]) pa_lvl_o[i] = lvl_i[i];
      else if (pa_pu_i[i]) pa_lvl_o[i] = 1'b1;
      else pa_lvl_o[i] = cnt[0];
    end
  end
endmodule // pfs_board

// ===== testbench/tb_pfs_pin_mux.sv
// Self-checking bench of the pin function select block
`include "pfs_consts.svh"
module tb_pfs_pin_mux;
  timeunit 1ns;
  timeprecision 100ps;
  import pfs_pkg::*;
  logic clk_sys, rst_b, wr, rd, wdog, chip_rst_b;
  logic [3:0] addr, drv, lvl, pa_i, pa_o, pa_oe, pa_pu;
  logic [7:0] wdata, rdata, rd_val;
  logic [2:0] pwm;
  pfs_clk_src_type clk_src;
  int mismatches, num_checks;

  pfs_pin_mux u_pfs_pin_mux (.CLK_SYS_I(clk_sys), .RST_B_I(rst_b),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .PA_I(pa_i), .PA_O(pa_o), .PA_OE_O(pa_oe),
    .PA_PU_O(pa_pu), .PWM_CH_I(pwm), .WDOG_RST_I(wdog),
    .CLK_SRC_O(clk_src), .CHIP_RST_B_O(chip_rst_b));
  pfs_board u_pfs_board (.clk_i(clk_sys), .pa_o_i(pa_o), .pa_oe_i(pa_oe),
    .pa_pu_i(pa_pu), .drv_i(drv), .lvl_i(lvl), .pa_lvl_o(pa_i),
    .pwm_o(pwm));

  ////////////////////////////////////////////////////////////////////////
  // Compare, bus cycles, waits
  task automatic chk(input string n, input logic [7:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk_sys);
    rd <= 1'b1; addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 rd_val = rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_rel;
    for (int k = 0; k < 60 && chip_rst_b !== 1'b1; k++) cyc(1);
    chk("release", {7'h0, chip_rst_b}, 8'h01);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    cyc(1);
    chk("oe", {4'h0, pa_oe}, 8'h00);
    chk("pu", {4'h0, pa_pu}, 8'h0f);
    chk("src", {6'h0, clk_src}, {6'h0, PFS_CLK_INT});
    cyc(31);
    chk("rst32", {7'h0, chip_rst_b}, 8'h00);
    cyc(1);
    chk("rst33", {7'h0, chip_rst_b}, 8'h01);
    $display("test reset done");
  endtask
  task automatic t_regs;
    logic [3:0] ra[7] = '{`PFS_OFS_PER, `PFS_OFS_GPS, `PFS_OFS_DDR,
      `PFS_OFS_DOUT, `PFS_OFS_PUE, `PFS_OFS_OSC, 4'h8};
    logic [7:0] rv[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h87, 8'h00, 8'h00};
    wr_reg(4'h8, 8'hff);
    for (int i = 0; i < 7; i++) begin
      rd_reg(ra[i]);
      chk("reg", rd_val, rv[i]);
    end
    $display("test regs done");
  endtask
  task automatic t_gpio;
    wr_reg(`PFS_OFS_DDR, 8'h05);
    wr_reg(`PFS_OFS_DOUT, 8'h81);
    cyc(3);
    chk("oe", {4'h0, pa_oe}, 8'h05);
    chk("out", {5'h0, pa_o[2:0] & 3'h5}, 8'h01);
    rd_reg(`PFS_OFS_DIN);
    chk("din", rd_val, 8'h81);
    $display("test gpio done");
  endtask
  task automatic t_alt;
    logic [2:0] prev;
    wr_reg(`PFS_OFS_PER, 8'h07);
    cyc(2);
    chk("per only", {5'h0, pa_o[2:0] & 3'h5}, 8'h01);
    chk("per oe", {4'h0, pa_oe}, 8'h05);
    wr_reg(`PFS_OFS_GPS, 8'h07);
    cyc(2);
    chk("alt oe", {4'h0, pa_oe}, 8'h07);
    for (int i = 0; i < 4; i++) begin
      prev = pwm;
      cyc(1);
      chk("pwm", {5'h0, pa_o[2:0]}, {5'h0, prev});
    end
    $display("test alt done");
  endtask
  task automatic t_clk;
    logic [7:0] ov[4] = '{8'h02, 8'h01, 8'h03, 8'h00};
    pfs_clk_src_type ev[4] = '{PFS_CLK_INT, PFS_CLK_PIN, PFS_CLK_CRYSTAL_PIN,
      PFS_CLK_INT};
    for (int i = 0; i < 4; i++) begin
      wr_reg(`PFS_OFS_OSC, ov[i]);
      cyc(2);
      chk("src", {6'h0, clk_src}, {6'h0, ev[i]});
    end
    $display("test clock done");
  endtask
  task automatic t_rst;
    @(posedge clk_sys);
    drv <= 4'ha;
    cyc(4);
    chk("pin rst", {7'h0, chip_rst_b}, 8'h00);
    chk("rst oe", {4'h0, pa_oe}, 8'h00);
    @(posedge clk_sys);
    drv <= 4'h2;
    wait_rel();
    rd_reg(`PFS_OFS_PER);
    chk("per", rd_val, 8'h00);
    wr_reg(`PFS_OFS_PER, 8'h80);
    wr_reg(`PFS_OFS_GPS, 8'h80);
    @(posedge clk_sys);
    drv <= 4'ha;
    cyc(5);
    chk("gpio pin", {7'h0, chip_rst_b}, 8'h01);
    rd_reg(`PFS_OFS_RSTCTL);
    chk("mode", rd_val, 8'h02);
    wr_reg(`PFS_OFS_DDR, 8'h80);
    cyc(2);
    chk("bit7 oe", {7'h0, pa_oe[3]}, 8'h01);
    chk("bit7 held", {7'h0, chip_rst_b}, 8'h01);
    @(posedge clk_sys);
    drv <= 4'h2;
    wdog <= 1'b1;
    cyc(2);
    chk("wdog", {7'h0, chip_rst_b}, 8'h00);
    @(posedge clk_sys);
    wdog <= 1'b0;
    wait_rel();
    rd_reg(`PFS_OFS_GPS);
    chk("gps", rd_val, 8'h00);
    wr_reg(`PFS_OFS_RSTCTL, 8'h01);
    cyc(2);
    chk("sw", {7'h0, chip_rst_b}, 8'h00);
    wait_rel();
    $display("test reset pin done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and main sequence
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    mismatches++;
    end_sim();
  end
  initial begin
    rst_b = 1'b0; wr = 1'b0; rd = 1'b0; wdog = 1'b0;
    addr = 4'h0; wdata = 8'h00; drv = 4'h2; lvl = 4'h0;
    mismatches = 0; num_checks = 0;
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset(); t_regs(); t_gpio(); t_alt(); t_clk(); t_rst();
    end_sim();
  end
endmodule // tb_pfs_pin_mux
